// *** hw/edge_detector.sv ***
// per-pin edge detection on function-gated pin levels
`timescale 1ns/10ps
`default_nettype none
module edge_detector (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    edge_det_if.det bus
);
    import ext_int_pkg::*;

    logic [NUM_EDGE-1:0] prev_ff;
    logic [NUM_EDGE-1:0] nxt_prev;
    logic sep_prev_ff;
    logic nxt_sep_prev;

    // one detector per pin; rising when the select bit is 1, falling otherwise
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EDGE; gi++) begin : g_edge
            assign bus.hit[gi] = bus.rise_sel[gi] ? (~prev_ff[gi] & bus.level[gi])
                                                  : (prev_ff[gi] & ~bus.level[gi]);
        end
    endgenerate

    // separate pin: mode picks falling, rising or both; reserved code detects nothing
    always_comb begin
        unique case (bus.sep_mode)
            SEP_FALL: bus.sep_hit = sep_prev_ff & ~bus.sep_level;
            SEP_RISE: bus.sep_hit = ~sep_prev_ff & bus.sep_level;
            SEP_BOTH: bus.sep_hit = sep_prev_ff ^ bus.sep_level;
            default: bus.sep_hit = 1'b0;
        endcase
    end

    // history; idle level is high since the pins are active low
    always_comb begin
        nxt_prev = bus.level;
        nxt_sep_prev = bus.sep_level;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_ff <= '1;
            sep_prev_ff <= 1'b1;
        end else if (clk_en) begin
            prev_ff <= nxt_prev;
            sep_prev_ff <= nxt_sep_prev;
        end
    end
endmodule
`default_nettype wire

// *** hw/ext_interrupt_flag_logic.sv ***
// external interrupt request flags with APB registers and a combined interrupt
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_flag_logic (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ext_int_pkg::ADDR_W-1:0] paddr,
    input wire logic [ext_int_pkg::DATA_W-1:0] pwdata,
    output logic [ext_int_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic edge_int_pin_0,
    input wire logic edge_int_pin_1,
    input wire logic sep_edge_int_pin,
    input wire logic [ext_int_pkg::NUM_WAKE-1:0] wakeup_pin,
    output logic [ext_int_pkg::NUM_EV-1:0] int_req,
    output logic irq
);
    import ext_int_pkg::*;

    // bus slave state
    apb_state_t apb_st_ff, nxt_apb_st;
    logic [DATA_W-1:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;

    // software registers
    logic [2:0] req_a_ff, nxt_req_a;
    logic [NUM_WAKE-1:0] wake_flag_ff, nxt_wake_flag;
    logic [7:0] enable_a_ff, nxt_enable_a;
    logic [1:0] edge_sel_ff, nxt_edge_sel;
    logic [NUM_WAKE-1:0] wake_edge_ff, nxt_wake_edge;
    logic [1:0] sep_sel_ff, nxt_sep_sel;
    logic func_int0_ff, nxt_func_int0;
    logic func_int1_ff, nxt_func_int1;
    logic [NUM_WAKE-1:0] func_wake_ff, nxt_func_wake;
    logic [NUM_EV-1:0] ev_ff, nxt_ev;
    logic [NUM_EV-1:0] ev_mask_ff, nxt_ev_mask;
    logic [NUM_EV-1:0] int_req_ff, nxt_int_req;
    logic irq_ff, nxt_irq;

    // decode and event terms
    logic commit;
    logic wr_commit;
    logic rd_commit;
    logic addr_hit;
    logic [DATA_W-1:0] rd_word;
    logic [2:0] set_a;
    logic [NUM_WAKE-1:0] set_wake;
    logic [NUM_EV-1:0] ev_set;
    logic sep_en;
    logic wake_en;

    edge_det_if edet ();

    edge_detector u_edge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .bus(edet)
    );

    // a pin in port mode looks idle high to its detector, so switching a low pin
    // in or out of interrupt mode shows up as a falling or rising edge
    assign edet.level[EDGE_IDX_INT0] = func_int0_ff ? edge_int_pin_0 : 1'b1;
    assign edet.level[EDGE_IDX_INT1] = func_int1_ff ? edge_int_pin_1 : 1'b1;
    assign edet.level[NUM_EDGE-1:EDGE_IDX_WAKE] = wakeup_pin | ~func_wake_ff;
    assign edet.rise_sel = {wake_edge_ff, edge_sel_ff};
    assign edet.sep_level = sep_edge_int_pin;
    assign edet.sep_mode = sep_mode_t'(sep_sel_ff);

    // enables and set pulses; the separate pin sets nothing while disabled
    assign sep_en = enable_a_ff[BIT_SEP];
    assign wake_en = enable_a_ff[BIT_WAKE_EN];
    assign set_a = {edet.sep_hit & sep_en, edet.hit[EDGE_IDX_INT1], edet.hit[EDGE_IDX_INT0]};
    assign set_wake = edet.hit[NUM_EDGE-1:EDGE_IDX_WAKE];
    assign ev_set = {|set_wake, set_a};

    // a transfer completes at the edge where pready is high
    assign commit = (apb_st_ff == AP_DONE) && psel && penable;
    assign wr_commit = commit && pwrite;
    assign rd_commit = commit && !pwrite;

    // read mux; reserved bits read zero
    always_comb begin
        rd_word = '0;
        addr_hit = 1'b1;
        unique case (paddr)
            OFS_REQ_A: rd_word[2:0] = req_a_ff;
            OFS_WAKE_REQ: rd_word[NUM_WAKE-1:0] = wake_flag_ff;
            OFS_ENABLE_A: rd_word[7:0] = enable_a_ff;
            OFS_EDGE_SEL: rd_word[1:0] = edge_sel_ff;
            OFS_WAKE_EDGE: rd_word[NUM_WAKE-1:0] = wake_edge_ff;
            OFS_SEP_SEL: rd_word[1:0] = sep_sel_ff;
            OFS_FUNC_INT0: rd_word[BIT_FUNC] = func_int0_ff;
            OFS_FUNC_INT1: rd_word[BIT_FUNC] = func_int1_ff;
            OFS_FUNC_WAKE: rd_word[NUM_WAKE-1:0] = func_wake_ff;
            OFS_EV_STATUS: rd_word[NUM_EV-1:0] = ev_ff;
            OFS_EV_MASK: rd_word[NUM_EV-1:0] = ev_mask_ff;
            default: addr_hit = 1'b0;
        endcase
    end

    // bus slave: one wait cycle so that pready and read data come from flops
    always_comb begin
        nxt_apb_st = apb_st_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        unique case (apb_st_ff)
            AP_IDLE: begin
                if (psel && penable) begin
                    nxt_apb_st = AP_DONE;
                    nxt_prdata = pwrite ? '0 : rd_word;
                    nxt_pslverr = !addr_hit;
                end
            end
            AP_DONE: begin
                nxt_apb_st = AP_IDLE;
                nxt_prdata = '0;
                nxt_pslverr = 1'b0;
            end
        endcase
    end

    // flag registers: written zero clears, written one keeps, a same-cycle set wins;
    // a flag set earlier than the write-back is lost if the write holds zero for it
    always_comb begin
        nxt_req_a = req_a_ff;
        nxt_wake_flag = wake_flag_ff;
        if (wr_commit && paddr == OFS_REQ_A) begin
            nxt_req_a = req_a_ff & pwdata[2:0];
        end
        if (wr_commit && paddr == OFS_WAKE_REQ) begin
            nxt_wake_flag = wake_flag_ff & pwdata[NUM_WAKE-1:0];
        end
        nxt_req_a = nxt_req_a | set_a;
        nxt_wake_flag = nxt_wake_flag | set_wake;
    end

    // control registers, plain read/write
    always_comb begin
        nxt_enable_a = enable_a_ff;
        nxt_edge_sel = edge_sel_ff;
        nxt_wake_edge = wake_edge_ff;
        nxt_sep_sel = sep_sel_ff;
        nxt_func_int0 = func_int0_ff;
        nxt_func_int1 = func_int1_ff;
        nxt_func_wake = func_wake_ff;
        nxt_ev_mask = ev_mask_ff;
        if (wr_commit) begin
            unique case (paddr)
                OFS_ENABLE_A: nxt_enable_a = pwdata[7:0];
                OFS_EDGE_SEL: nxt_edge_sel = pwdata[1:0];
                OFS_WAKE_EDGE: nxt_wake_edge = pwdata[NUM_WAKE-1:0];
                OFS_SEP_SEL: nxt_sep_sel = pwdata[1:0];
                OFS_FUNC_INT0: nxt_func_int0 = pwdata[BIT_FUNC];
                OFS_FUNC_INT1: nxt_func_int1 = pwdata[BIT_FUNC];
                OFS_FUNC_WAKE: nxt_func_wake = pwdata[NUM_WAKE-1:0];
                OFS_EV_MASK: nxt_ev_mask = pwdata[NUM_EV-1:0];
                default: nxt_enable_a = enable_a_ff;
            endcase
        end
    end

    // sticky events cleared by reading them; a new event in the read cycle survives
    always_comb begin
        nxt_ev = ev_ff;
        if (rd_commit && paddr == OFS_EV_STATUS) begin
            nxt_ev = RST_EV;
        end
        nxt_ev = nxt_ev | ev_set;
    end

    // per-source requests; built from next values so outputs track the flags exactly
    always_comb begin
        nxt_int_req[EV_INT0] = nxt_req_a[BIT_INT0] & nxt_enable_a[BIT_INT0];
        nxt_int_req[EV_INT1] = nxt_req_a[BIT_INT1] & nxt_enable_a[BIT_INT1];
        nxt_int_req[EV_SEP] = nxt_req_a[BIT_SEP] & nxt_enable_a[BIT_SEP];
        nxt_int_req[EV_WAKE] = (|nxt_wake_flag) & nxt_enable_a[BIT_WAKE_EN];
        nxt_irq = |(nxt_ev & nxt_ev_mask);
    end

    // single register stage for everything; clk_en low freezes the block
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            apb_st_ff <= AP_IDLE;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
            req_a_ff <= RST_BYTE[2:0];
            wake_flag_ff <= RST_BYTE;
            enable_a_ff <= RST_BYTE;
            edge_sel_ff <= RST_BYTE[1:0];
            wake_edge_ff <= RST_BYTE;
            sep_sel_ff <= RST_SEP_SEL;
            func_int0_ff <= 1'b0;
            func_int1_ff <= 1'b0;
            func_wake_ff <= RST_BYTE;
            ev_ff <= RST_EV;
            ev_mask_ff <= RST_EV;
            int_req_ff <= RST_EV;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            apb_st_ff <= nxt_apb_st;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            req_a_ff <= nxt_req_a;
            wake_flag_ff <= nxt_wake_flag;
            enable_a_ff <= nxt_enable_a;
            edge_sel_ff <= nxt_edge_sel;
            wake_edge_ff <= nxt_wake_edge;
            sep_sel_ff <= nxt_sep_sel;
            func_int0_ff <= nxt_func_int0;
            func_int1_ff <= nxt_func_int1;
            func_wake_ff <= nxt_func_wake;
            ev_ff <= nxt_ev;
            ev_mask_ff <= nxt_ev_mask;
            int_req_ff <= nxt_int_req;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata = prdata_ff;
    assign pready = apb_st_ff[1];
    assign pslverr = pslverr_ff;
    assign int_req = int_req_ff;
    assign irq = irq_ff;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_int0_enter_low;
        clk_en && $rose(func_int0_ff) && !edge_int_pin_0 && !edge_sel_ff[BIT_INT0];
    endsequence

    sequence s_int0_leave_low;
        clk_en && $fell(func_int0_ff) && !edge_int_pin_0 && edge_sel_ff[BIT_INT0];
    endsequence

    sequence s_int1_enter_low;
        clk_en && $rose(func_int1_ff) && !edge_int_pin_1 && !edge_sel_ff[BIT_INT1];
    endsequence

    sequence s_int1_leave_low;
        clk_en && $fell(func_int1_ff) && !edge_int_pin_1 && edge_sel_ff[BIT_INT1];
    endsequence

    a_int0_enter_flag: assert property (s_int0_enter_low |=> req_a_ff[BIT_INT0])
        else $error("int0 flag not set on entry into interrupt mode");
    a_int0_leave_flag: assert property (s_int0_leave_low |=> req_a_ff[BIT_INT0])
        else $error("int0 flag not set on leaving interrupt mode");
    a_int1_enter_flag: assert property (s_int1_enter_low |=> req_a_ff[BIT_INT1])
        else $error("int1 flag not set on entry into interrupt mode");
    a_int1_leave_flag: assert property (s_int1_leave_low |=> req_a_ff[BIT_INT1])
        else $error("int1 flag not set on leaving interrupt mode");
    a_wake_enter_flag: assert property (clk_en && $rose(func_wake_ff[NUM_WAKE-1])
            && !wakeup_pin[NUM_WAKE-1] && !wake_edge_ff[NUM_WAKE-1] |=> wake_flag_ff[NUM_WAKE-1])
        else $error("wakeup 7 flag not set on entry into interrupt mode");
    a_wake_leave_flag: assert property (clk_en && $fell(func_wake_ff[0])
            && !wakeup_pin[0] && wake_edge_ff[0] |=> wake_flag_ff[0])
        else $error("wakeup 0 flag not set on leaving interrupt mode");
    a_sep_gated_flag: assert property (clk_en && !req_a_ff[BIT_SEP] && !sep_en
            |=> !req_a_ff[BIT_SEP])
        else $error("separate pin flag set while disabled");
    a_clear_by_zero: assert property (clk_en && wr_commit && paddr == OFS_REQ_A
            && !pwdata[BIT_INT0] && !set_a[BIT_INT0] |=> !req_a_ff[BIT_INT0])
        else $error("int0 flag not cleared by a zero write");
    a_keep_by_one: assert property (clk_en && wr_commit && paddr == OFS_WAKE_REQ
            && pwdata[0] && wake_flag_ff[0] |=> wake_flag_ff[0])
        else $error("wakeup 0 flag lost on a one write");
    a_wake_shared_req: assert property (##1 int_req[EV_WAKE] == ((|wake_flag_ff) && wake_en))
        else $error("shared wakeup request does not match flags and enable");
    a_int0_req_gate: assert property (int_req[EV_INT0] |-> req_a_ff[BIT_INT0] && enable_a_ff[BIT_INT0])
        else $error("int0 request without flag and enable");
    a_wake_edge_rise: assert property (clk_en && wake_edge_ff[1] && func_wake_ff[1]
            && $rose(wakeup_pin[1]) && $stable(func_wake_ff[1]) |=> wake_flag_ff[1])
        else $error("wakeup 1 rising edge missed");
    a_apb_one_wait: assert property (clk_en && psel && penable && !pready |=> pready) // bus answer
        else $error("bus answer not given after one wait cycle");
endmodule
`default_nettype wire

// *** inc/edge_det_if.sv ***
// signals between the flag logic and its edge detector
`timescale 1ns/10ps
`default_nettype none
interface edge_det_if;
    import ext_int_pkg::*;
    logic [NUM_EDGE-1:0] level;
    logic [NUM_EDGE-1:0] rise_sel;
    logic sep_level;
    sep_mode_t sep_mode;
    logic [NUM_EDGE-1:0] hit;
    logic sep_hit;
    modport owner (output level, output rise_sel, output sep_level, output sep_mode, input hit, input sep_hit);
    modport det (input level, input rise_sel, input sep_level, input sep_mode, output hit, output sep_hit);
endinterface
`default_nettype wire

// *** inc/ext_int_pkg.sv ***
// constants, register map and types for the external interrupt flag logic
package ext_int_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_WAKE = 8;
    localparam int NUM_EDGE = 10;           // int0, int1, wakeup 0..7
    localparam int EDGE_IDX_INT0 = 0;
    localparam int EDGE_IDX_INT1 = 1;
    localparam int EDGE_IDX_WAKE = 2;

    // register byte offsets
    localparam logic [7:0] OFS_REQ_A = 8'h00;      // int_request_reg_a
    localparam logic [7:0] OFS_WAKE_REQ = 8'h04;   // wakeup_request_reg
    localparam logic [7:0] OFS_ENABLE_A = 8'h08;   // int_enable_reg_a
    localparam logic [7:0] OFS_EDGE_SEL = 8'h0c;   // edge_select_reg
    localparam logic [7:0] OFS_WAKE_EDGE = 8'h10;  // wakeup_edge_reg
    localparam logic [7:0] OFS_SEP_SEL = 8'h14;    // sep_edge_select_reg
    localparam logic [7:0] OFS_FUNC_INT0 = 8'h18;  // pin_func_reg_int0
    localparam logic [7:0] OFS_FUNC_INT1 = 8'h1c;  // pin_func_reg_int1
    localparam logic [7:0] OFS_FUNC_WAKE = 8'h20;  // pin_func_reg_wakeup
    localparam logic [7:0] OFS_EV_STATUS = 8'h24;  // event status, read clears
    localparam logic [7:0] OFS_EV_MASK = 8'h28;    // event mask

    // field positions
    localparam int BIT_INT0 = 0;           // flag, enable and edge-select position
    localparam int BIT_INT1 = 1;
    localparam int BIT_SEP = 2;            // flag and enable of the separate pin
    localparam int BIT_WAKE_EN = 5;        // shared wakeup enable
    localparam int BIT_FUNC = 0;           // function bit in int0/int1 function regs
    localparam int EV_INT0 = 0;
    localparam int EV_INT1 = 1;
    localparam int EV_SEP = 2;
    localparam int EV_WAKE = 3;
    localparam int NUM_EV = 4;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_SEP_SEL = 2'h0;
    localparam logic [NUM_EV-1:0] RST_EV = 4'h0;

    // separate pin edge modes
    typedef enum logic [1:0] {
        SEP_FALL = 2'h0,
        SEP_RISE = 2'h1,
        SEP_BOTH = 2'h2,
        SEP_NONE = 2'h3
    } sep_mode_t;

    // bus slave states
    typedef enum logic [1:0] {
        AP_IDLE = 2'b01,
        AP_DONE = 2'b10
    } apb_state_t;
endpackage

// *** verification/ext_interrupt_flag_logic_bench.sv ***
// self-checking bench for the external interrupt flag logic
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_flag_logic_bench;
    import ext_int_pkg::*;
    logic mclk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr, err, irq;
    logic pin0, pin1, pin_sep;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [NUM_WAKE-1:0] pin_wake;
    logic [NUM_EV-1:0] int_req;
    int fail_count, n_compared;

    ext_interrupt_flag_logic i_ext_interrupt_flag_logic (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .edge_int_pin_0(pin0), .edge_int_pin_1(pin1),
        .sep_edge_int_pin(pin_sep), .wakeup_pin(pin_wake), .int_req(int_req), .irq(irq));
    pin_source_model i_pin_source_model (.mclk(mclk), .edge_int_pin_0(pin0), .edge_int_pin_1(pin1),
        .sep_edge_int_pin(pin_sep), .wakeup_pin(pin_wake));

    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; the request stays put until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("[ERR] pready expected 1 seen %b", pready);
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pins(input logic p0, input logic p1, input logic ps, input logic [7:0] pw);
        i_pin_source_model.drive(p0, p1, ps, pw);
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // main sequence
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 40; a += 4) begin
            rdchk("reset value", 8'(a), 32'h0);
        end
        xfer(1'b0, 8'h2c, 32'h0);
        chk("unmapped pslverr", 32'h1, 32'(err));
        // pin low while in port mode: entering interrupt mode is a falling edge
        pins(1'b0, 1'b0, 1'b1, 8'h00);
        wr(OFS_ENABLE_A, 32'h0);
        wr(OFS_FUNC_INT0, 32'h1);
        rdchk("int0 flag", OFS_REQ_A, 32'h1);
        wr(OFS_FUNC_INT1, 32'h1);
        rdchk("int1 flag", OFS_REQ_A, 32'h3);
        chk("masked int_req", 32'h0, 32'(int_req));
        wr(OFS_ENABLE_A, 32'h3);
        rdchk("enable", OFS_ENABLE_A, 32'h3);
        chk("enabled int_req", 32'h3, 32'(int_req));
        wr(OFS_REQ_A, 32'hfd);
        rdchk("clear one flag", OFS_REQ_A, 32'h1);
        wr(OFS_REQ_A, 32'hfe);
        rdchk("clear other flag", OFS_REQ_A, 32'h0);
        chk("cleared int_req", 32'h0, 32'(int_req));
        // rising selected: leaving interrupt mode with the pin low counts
        wr(OFS_ENABLE_A, 32'h0);
        wr(OFS_EDGE_SEL, 32'h3);
        wr(OFS_FUNC_INT0, 32'h0);
        wr(OFS_FUNC_INT1, 32'h0);
        rdchk("release flags", OFS_REQ_A, 32'h3);
        wr(OFS_REQ_A, 32'h0);
        wr(OFS_FUNC_INT0, 32'h1);
        rdchk("wrong direction", OFS_REQ_A, 32'h0);
        // wakeup pins, mixed entry and exit in one write
        wr(OFS_FUNC_WAKE, 32'ha5);
        rdchk("wakeup entry", OFS_WAKE_REQ, 32'ha5);
        wr(OFS_WAKE_REQ, 32'h0);
        wr(OFS_WAKE_EDGE, 32'hff);
        wr(OFS_FUNC_WAKE, 32'h0f);
        rdchk("wakeup exit", OFS_WAKE_REQ, 32'ha0);
        wr(OFS_WAKE_REQ, 32'h0);
        wr(OFS_WAKE_EDGE, 32'h0);
        pins(1'b0, 1'b0, 1'b1, 8'hff);
        wr(OFS_FUNC_WAKE, 32'hff);
        wr(OFS_ENABLE_A, 32'h20);
        pins(1'b0, 1'b0, 1'b1, 8'hf7);
        rdchk("wakeup pin edge", OFS_WAKE_REQ, 32'h08);
        chk("wakeup int_req", 32'h8, 32'(int_req));
        wr(OFS_WAKE_REQ, 32'h0);
        // separate pin ignored while its enable is low, then every mode
        pins(1'b0, 1'b0, 1'b0, 8'hf7);
        pins(1'b0, 1'b0, 1'b1, 8'hf7);
        rdchk("sep disabled", OFS_REQ_A, 32'h0);
        wr(OFS_ENABLE_A, 32'h4);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_SEP_SEL, 32'(m));
            pins(1'b0, 1'b0, 1'b0, 8'hf7);
            rdchk("sep falling", OFS_REQ_A, (m == 0 || m == 2) ? 32'h4 : 32'h0);
            chk("sep int_req", (m == 0 || m == 2) ? 32'h4 : 32'h0, 32'(int_req));
            wr(OFS_REQ_A, 32'h0);
            pins(1'b0, 1'b0, 1'b1, 8'hf7);
            rdchk("sep rising", OFS_REQ_A, (m == 1 || m == 2) ? 32'h4 : 32'h0);
            wr(OFS_REQ_A, 32'h0);
        end
        // a flag raised between read and write-back is lost
        wr(OFS_EDGE_SEL, 32'h0);
        pins(1'b1, 1'b0, 1'b1, 8'hf7);
        rdchk("before write-back", OFS_REQ_A, 32'h0);
        pins(1'b0, 1'b0, 1'b1, 8'hf7);
        wr(OFS_REQ_A, rd & 32'hfd);
        rdchk("lost request", OFS_REQ_A, 32'h0);
        // event status, mask and the combined interrupt line
        xfer(1'b0, OFS_EV_STATUS, 32'h0);
        wr(OFS_EV_MASK, 32'h0);
        pins(1'b1, 1'b0, 1'b1, 8'hf7);
        pins(1'b0, 1'b0, 1'b1, 8'hf7);
        rdchk("int0 again", OFS_REQ_A, 32'h1);
        chk("irq masked", 32'h0, 32'(irq));
        wr(OFS_EV_MASK, 32'h1);
        rdchk("mask", OFS_EV_MASK, 32'h1);
        chk("irq raised", 32'h1, 32'(irq));
        rdchk("event status", OFS_EV_STATUS, 32'h1);
        rdchk("status cleared", OFS_EV_STATUS, 32'h0);
        chk("irq cleared", 32'h0, 32'(irq));
        // clk_en low freezes the detector history, so a pin pulse inside the stall is not seen
        wr(OFS_REQ_A, 32'h0);
        @(posedge mclk);
        clk_en <= 1'b0;
        pins(1'b1, 1'b0, 1'b1, 8'hf7);
        pins(1'b0, 1'b0, 1'b1, 8'hf7);
        @(posedge mclk);
        clk_en <= 1'b1;
        rdchk("frozen pulse", OFS_REQ_A, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire

// *** verification/pin_source_model.sv ***
// signal sources that drive the active-low external interrupt pins
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
    input wire logic mclk,
    output logic edge_int_pin_0,
    output logic edge_int_pin_1,
    output logic sep_edge_int_pin,
    output logic [7:0] wakeup_pin
);
    // pins rest high, so a source that never moves raises no edge
    initial begin
        edge_int_pin_0 = 1'b1;
        edge_int_pin_1 = 1'b1;
        sep_edge_int_pin = 1'b1;
        wakeup_pin = 8'hff;
    end
    // new levels land just after a rising edge, like a synchronous source
    task automatic drive(input logic p0, input logic p1, input logic ps, input logic [7:0] pw);
        @(posedge mclk);
        edge_int_pin_0 <= p0;
        edge_int_pin_1 <= p1;
        sep_edge_int_pin <= ps;
        wakeup_pin <= pw;
    endtask
endmodule
`default_nettype wire
